// >>> design/bmc_pkg.sv
// basic mode control package: register offset, field positions, reset values,
// timing counts and the types shared by the control register, its checker and the bench.
// assumes a single 20 MHz clock and a 5-bit management register address.
package bmc_pkg;

  // register map
  localparam logic [4:0] BMC_OFFSET = 5'h00;
  localparam int REG_W = 16;

  // field positions inside the 16-bit word
  localparam int RESET_BIT = 15;
  localparam int LOOPBACK_BIT = 14;
  localparam int SPEED_BIT = 13;
  localparam int ANEG_BIT = 12;
  localparam int PDOWN_BIT = 11;
  localparam int ISOLATE_BIT = 10;
  localparam int RESTART_BIT = 9;
  localparam int DUPLEX_BIT = 8;
  localparam int COLTEST_BIT = 7;
  localparam int RSVD_W = 7;
  localparam logic [RSVD_W-1:0] RSVD_READ = 7'h00;

  // reset values that no strap supplies
  localparam logic LOOPBACK_RST = 1'b0;
  localparam logic PDOWN_RST = 1'b0;
  localparam logic RESTART_RST = 1'b0;
  localparam logic COLTEST_RST = 1'b0;
  // enhanced pin mode values for fields that only basic mode straps
  localparam logic ENH_SPEED_RST = 1'b1;
  localparam logic ENH_DUPLEX_RST = 1'b1;
  localparam logic ENH_ISOLATE_RST = 1'b0;
  // strap register contents before the pins are caught
  localparam logic STRAP_ANEG_RST = 1'b1;
  localparam logic STRAP_SPEED_RST = 1'b1;
  localparam logic STRAP_DUPLEX_RST = 1'b1;
  localparam logic STRAP_ISOLATE_RST = 1'b0;

  // timing
  localparam int CLK_PERIOD_PS = 50000;
  localparam int SOFT_RESET_NS = 1000;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SR_CNT_W = 5;
  localparam logic [SR_CNT_W-1:0] SR_CNT_LOAD = SR_CNT_W'(SOFT_RESET_CYCLES - 1);
  localparam logic [SR_CNT_W-1:0] SR_CNT_ZERO = 5'h00;
  localparam int BIT_TIME_100_PS = 10000;
  localparam int COL_ASSERT_BIT_TIMES = 512;
  localparam int COL_DEASSERT_BIT_TIMES = 4;
  localparam int COL_ASSERT_MAX_CYCLES =
    (COL_ASSERT_BIT_TIMES * BIT_TIME_100_PS / CLK_PERIOD_PS < 1) ? 1 :
    COL_ASSERT_BIT_TIMES * BIT_TIME_100_PS / CLK_PERIOD_PS;
  localparam int COL_DEASSERT_MAX_CYCLES =
    (COL_DEASSERT_BIT_TIMES * BIT_TIME_100_PS / CLK_PERIOD_PS < 1) ? 1 :
    COL_DEASSERT_BIT_TIMES * BIT_TIME_100_PS / CLK_PERIOD_PS;
  // the collision path is one register deep, inside both limits above
  localparam int COL_PATH_CYCLES = 1;

  typedef enum logic [1:0] {
    ST_STRAP,
    ST_RUN,
    ST_SOFT_RESET
  } bmc_state_t;

  // writable control fields of the register
  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic aneg_en;
    logic power_down;
    logic isolate;
    logic restart_an;
    logic full_duplex;
    logic col_test;
  } bmc_ctrl_t;

  typedef struct packed {
    logic aneg_en;
    logic speed_100;
    logic full_duplex;
    logic isolate;
  } bmc_strap_t;

  // receive side toward the mac
  typedef struct packed {
    logic [3:0] rxd;
    logic rx_dv;
    logic rx_er;
    logic crs;
  } bmc_rx_t;

  localparam int RX_W = $bits(bmc_rx_t);

endpackage

// >>> design/bmc_sel_reg.sv
// registered two-way select with an isolating output enable.
// assumes both sources are synchronous to clk.
`timescale 1ns/1ps
module bmc_sel_reg #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sel,
  input wire logic [W-1:0] src_a,
  input wire logic [W-1:0] src_b,
  input wire logic drive,
  output logic [W-1:0] q,
  output logic oe
);

  logic [W-1:0] pick;

  // a when sel low, b when high; idle low while not driving
  assign pick = drive ? (sel ? src_b : src_a) : '0;

  // one register stage keeps the mac outputs glitch free
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      q <= '0;
      oe <= 1'b0;
    end
    else
    begin
      q <= pick;
      oe <= drive;
    end
  end

endmodule

// >>> design/bmc_basic_mode_control.sv
// basic mode control register of a 10/100 phy with its control effects.
// assumes management accesses, mii signals and strap pins are synchronous to clk.
// Notes on behaviour
// - reset bit resets standard set, self clears
// - vendor extended registers untouched by soft reset
// - loopback routes mii transmit to receive
// - speed bit picks 10 or 100 forced
// - basic mode: speed reset value from strap
// - aneg on ignores speed and duplex bits
// - aneg enable reset value from strap
// - power down keeps register access alive
// - power down is bit or pin, pin only in enhanced pin mode
// - isolate detaches mii, management stays
// - isolate in rmii leader stops refclk
// - basic mode: isolate reset value from strap
// - restart writes ignored while aneg off
// - restart bit reads one until initiated
// - clearing restart never disturbs running aneg
// - duplex bit forced select, strapped in basic
// - collision test raises col after tx_en
// - collision test drops col after tx_en
`timescale 1ns/1ps
module bmc_basic_mode_control (
  input wire logic clk,
  input wire logic reset,
  // management register port
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  // pin mode and straps
  input wire logic basic_mode,
  input wire logic rmii_leader,
  input wire logic strap_aneg_en,
  input wire logic strap_speed_100,
  input wire logic strap_full_duplex,
  input wire logic strap_isolate,
  input wire logic interrupt_powerdown_pin_n,
  // auto-negotiation engine
  input wire logic an_initiated,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  output logic an_enable,
  output logic an_restart_req,
  // operating controls
  output logic port_speed_100,
  output logic port_full_duplex,
  output logic phy_power_down,
  output logic std_regs_reset,
  output logic refclk_out_en,
  // mii toward the mac
  input wire logic [3:0] mii_txd,
  input wire logic mii_tx_en,
  input wire logic mii_tx_er,
  input wire logic [3:0] line_rxd,
  input wire logic line_rx_dv,
  input wire logic line_rx_er,
  input wire logic line_crs,
  input wire logic line_col,
  output bmc_pkg::bmc_rx_t mii_rx,
  output logic mii_rx_oe,
  output logic mii_col,
  output logic mii_col_oe
);

  bmc_pkg::bmc_state_t state_q;
  bmc_pkg::bmc_state_t state_d;
  bmc_pkg::bmc_ctrl_t ctrl_q;
  bmc_pkg::bmc_ctrl_t ctrl_d;
  bmc_pkg::bmc_ctrl_t dflt;
  bmc_pkg::bmc_strap_t strap_q;
  bmc_pkg::bmc_strap_t strap_src;
  logic [bmc_pkg::SR_CNT_W-1:0] sr_cnt_q;
  logic [bmc_pkg::SR_CNT_W-1:0] sr_cnt_d;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic an_enable_q;
  logic restart_req_q;
  logic speed_q;
  logic duplex_q;
  logic pdown_q;
  logic std_reset_q;
  logic refclk_en_q;

  // address decode and write qualification
  logic hit;
  logic wr_hit;
  logic wr_ok;
  logic wr_soft_reset;
  logic wr_restart;
  logic pin_pdown;
  logic load_dflt;
  logic sr_done;
  logic [15:0] read_word;
  logic eff_speed;
  logic eff_duplex;
  logic eff_pdown;
  logic rx_drive;
  bmc_pkg::bmc_rx_t loop_rx;
  bmc_pkg::bmc_rx_t line_rx;

  assign hit = (mgmt_addr == bmc_pkg::BMC_OFFSET);
  assign wr_hit = mgmt_wr & hit;
  // writes land only in normal running; the strap cycle and a soft reset swallow them
  assign wr_ok = wr_hit & (state_q == bmc_pkg::ST_RUN);
  assign wr_soft_reset = wr_ok & mgmt_wdata[bmc_pkg::RESET_BIT];
  // restart honoured only while aneg is already on; a zero write never clears it
  assign wr_restart = wr_ok & ~wr_soft_reset & ctrl_q.aneg_en
    & mgmt_wdata[bmc_pkg::RESTART_BIT];
  // pin input only exists in enhanced pin mode
  assign pin_pdown = ~basic_mode & ~interrupt_powerdown_pin_n;
  assign sr_done = (state_q == bmc_pkg::ST_SOFT_RESET) && (sr_cnt_q == bmc_pkg::SR_CNT_ZERO);
  assign load_dflt = (state_q == bmc_pkg::ST_STRAP) | sr_done;

  // straps are taken from the pins in the first cycle after reset, later from the latch
  assign strap_src.aneg_en = (state_q == bmc_pkg::ST_STRAP) ? strap_aneg_en : strap_q.aneg_en;
  assign strap_src.speed_100 = (state_q == bmc_pkg::ST_STRAP) ? strap_speed_100 : strap_q.speed_100;
  assign strap_src.full_duplex = (state_q == bmc_pkg::ST_STRAP) ? strap_full_duplex : strap_q.full_duplex;
  assign strap_src.isolate = (state_q == bmc_pkg::ST_STRAP) ? strap_isolate : strap_q.isolate;

  // defaults of the standard set; basic mode takes more fields from straps
  assign dflt.loopback = bmc_pkg::LOOPBACK_RST;
  assign dflt.speed_100 = basic_mode ? strap_src.speed_100 : bmc_pkg::ENH_SPEED_RST;
  assign dflt.aneg_en = strap_src.aneg_en;
  assign dflt.power_down = bmc_pkg::PDOWN_RST;
  assign dflt.isolate = basic_mode ? strap_src.isolate : bmc_pkg::ENH_ISOLATE_RST;
  assign dflt.restart_an = bmc_pkg::RESTART_RST;
  assign dflt.full_duplex = basic_mode ? strap_src.full_duplex : bmc_pkg::ENH_DUPLEX_RST;
  assign dflt.col_test = bmc_pkg::COLTEST_RST;

  // next control value: defaults, then writes, then hardware sets win
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (load_dflt)
    begin
      ctrl_d = dflt;
    end
    else if (wr_ok & ~wr_soft_reset)
    begin
      ctrl_d.loopback = mgmt_wdata[bmc_pkg::LOOPBACK_BIT];
      ctrl_d.speed_100 = mgmt_wdata[bmc_pkg::SPEED_BIT];
      ctrl_d.aneg_en = mgmt_wdata[bmc_pkg::ANEG_BIT];
      ctrl_d.power_down = mgmt_wdata[bmc_pkg::PDOWN_BIT];
      ctrl_d.isolate = mgmt_wdata[bmc_pkg::ISOLATE_BIT];
      ctrl_d.full_duplex = mgmt_wdata[bmc_pkg::DUPLEX_BIT];
      ctrl_d.col_test = mgmt_wdata[bmc_pkg::COLTEST_BIT];
    end
    // restart clears when the engine reports initiation, a fresh request wins
    if (!load_dflt && an_initiated)
    begin
      ctrl_d.restart_an = 1'b0;
    end
    if (wr_restart)
    begin
      ctrl_d.restart_an = 1'b1;
    end
    if (!load_dflt && pin_pdown)
    begin
      ctrl_d.power_down = 1'b1;
    end
  end

  // soft reset sequencer
  always_comb
  begin
    state_d = state_q;
    sr_cnt_d = sr_cnt_q;
    case (state_q)
      bmc_pkg::ST_STRAP:
      begin
        state_d = bmc_pkg::ST_RUN;
      end
      bmc_pkg::ST_RUN:
      begin
        if (wr_soft_reset)
        begin
          state_d = bmc_pkg::ST_SOFT_RESET;
          sr_cnt_d = bmc_pkg::SR_CNT_LOAD;
        end
      end
      bmc_pkg::ST_SOFT_RESET:
      begin
        if (sr_done)
        begin
          state_d = bmc_pkg::ST_RUN;
        end
        else
        begin
          sr_cnt_d = sr_cnt_q - 1'b1;
        end
      end
      default:
      begin
        state_d = bmc_pkg::ST_STRAP;
      end
    endcase
  end

  // readback: reset bit shows the sequence, reserved bits are zero
  assign read_word = {(state_q == bmc_pkg::ST_SOFT_RESET), ctrl_q.loopback, ctrl_q.speed_100,
    ctrl_q.aneg_en, ctrl_q.power_down, ctrl_q.isolate, ctrl_q.restart_an, ctrl_q.full_duplex,
    ctrl_q.col_test, bmc_pkg::RSVD_READ};

  // forced speed and duplex only count while aneg is off
  assign eff_speed = ctrl_q.aneg_en ? an_speed_100 : ctrl_q.speed_100;
  assign eff_duplex = ctrl_q.aneg_en ? an_full_duplex : ctrl_q.full_duplex;
  assign eff_pdown = ctrl_q.power_down | pin_pdown;

  // state, counter and strap latch
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= bmc_pkg::ST_STRAP;
      sr_cnt_q <= bmc_pkg::SR_CNT_ZERO;
      strap_q <= {bmc_pkg::STRAP_ANEG_RST, bmc_pkg::STRAP_SPEED_RST, bmc_pkg::STRAP_DUPLEX_RST,
        bmc_pkg::STRAP_ISOLATE_RST};
    end
    else
    begin
      state_q <= state_d;
      sr_cnt_q <= sr_cnt_d;
      strap_q <= strap_src;
    end
  end

  // the control fields themselves
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_q <= {bmc_pkg::LOOPBACK_RST, bmc_pkg::ENH_SPEED_RST, bmc_pkg::STRAP_ANEG_RST,
        bmc_pkg::PDOWN_RST, bmc_pkg::ENH_ISOLATE_RST, bmc_pkg::RESTART_RST,
        bmc_pkg::ENH_DUPLEX_RST, bmc_pkg::COLTEST_RST};
    end
    else
    begin
      ctrl_q <= ctrl_d;
    end
  end

  // read port stays alive in power down and isolation
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q <= (mgmt_rd & hit) ? read_word : 16'h0000;
      rvalid_q <= mgmt_rd;
    end
  end

  // registered controls toward the phy core
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      an_enable_q <= bmc_pkg::STRAP_ANEG_RST;
      restart_req_q <= 1'b0;
      speed_q <= bmc_pkg::ENH_SPEED_RST;
      duplex_q <= bmc_pkg::ENH_DUPLEX_RST;
      pdown_q <= 1'b0;
      std_reset_q <= 1'b0;
      refclk_en_q <= 1'b1;
    end
    else
    begin
      an_enable_q <= ctrl_d.aneg_en;
      restart_req_q <= ctrl_d.restart_an & ctrl_d.aneg_en;
      speed_q <= eff_speed;
      duplex_q <= eff_duplex;
      pdown_q <= eff_pdown;
      // only the standard set sees this; vendor registers have no reset tap here
      std_reset_q <= (state_d == bmc_pkg::ST_SOFT_RESET);
      refclk_en_q <= ~(ctrl_d.isolate & rmii_leader);
    end
  end

  // receive path: line or looped transmit data, released while isolated
  assign rx_drive = ~ctrl_q.isolate;
  assign loop_rx.rxd = mii_txd;
  assign loop_rx.rx_dv = mii_tx_en;
  assign loop_rx.rx_er = mii_tx_er;
  assign loop_rx.crs = mii_tx_en;
  assign line_rx.rxd = line_rxd;
  assign line_rx.rx_dv = line_rx_dv;
  assign line_rx.rx_er = line_rx_er;
  assign line_rx.crs = line_crs;

  bmc_sel_reg #(
    .W(bmc_pkg::RX_W)
  ) u_rx_sel (
    .clk(clk),
    .reset(reset),
    .sel(ctrl_q.loopback),
    .src_a(line_rx),
    .src_b(loop_rx),
    .drive(rx_drive),
    .q(mii_rx),
    .oe(mii_rx_oe)
  );

  // collision test follows tx_en one clock later, well inside the assert limit and equal to the one-cycle deassert limit
  bmc_sel_reg #(
    .W(1)
  ) u_col_sel (
    .clk(clk),
    .reset(reset),
    .sel(ctrl_q.col_test),
    .src_a(line_col & ~ctrl_q.loopback),
    .src_b(mii_tx_en),
    .drive(rx_drive),
    .q(mii_col),
    .oe(mii_col_oe)
  );

  assign mgmt_rdata = rdata_q;
  assign mgmt_rvalid = rvalid_q;
  assign an_enable = an_enable_q;
  assign an_restart_req = restart_req_q;
  assign port_speed_100 = speed_q;
  assign port_full_duplex = duplex_q;
  assign phy_power_down = pdown_q;
  assign std_regs_reset = std_reset_q;
  assign refclk_out_en = refclk_en_q;

endmodule

// >>> sim/bmc_chk.sv
// port checker for the basic mode control register.
// assumes it is bound to bmc_basic_mode_control and sees its ports only.
`timescale 1ns/1ps
module bmc_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid,
  input wire logic basic_mode,
  input wire logic rmii_leader,
  input wire logic interrupt_powerdown_pin_n,
  input wire logic an_initiated,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic an_enable,
  input wire logic an_restart_req,
  input wire logic port_speed_100,
  input wire logic port_full_duplex,
  input wire logic phy_power_down,
  input wire logic std_regs_reset,
  input wire logic refclk_out_en,
  input wire bmc_pkg::bmc_rx_t mii_rx,
  input wire logic mii_rx_oe,
  input wire logic mii_col,
  input wire logic mii_col_oe
);
  logic live_q;
  logic [5:0] hi_q;

  // live from the second edge: the strap edge refuses writes
  always_ff @(posedge clk or posedge reset)
    if (reset)
      live_q <= 1'b0;
    else
      live_q <= 1'b1;

  // length of the soft reset pulse, read back at its falling edge
  always_ff @(posedge clk or posedge reset)
    if (reset)
      hi_q <= 6'h00;
    else
      hi_q <= std_regs_reset ? hi_q + 6'h01 : 6'h00;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_soft_wr;
    live_q && mgmt_wr && mgmt_addr == 5'h00 && mgmt_wdata[15] && !std_regs_reset;
  endsequence
  // a restart write in the same cycle wins, so leave it out
  sequence s_an_started;
    an_initiated && !mgmt_wr;
  endsequence

  a_soft_reset_start: assert property (s_soft_wr |=> std_regs_reset)
    else $error("soft reset did not start");
  a_soft_reset_len: assert property ($fell(std_regs_reset) |-> hi_q inside {[6'h14:6'h15]})
    else $error("soft reset length wrong");
  a_read_in_pdown: assert property (phy_power_down && mgmt_rd |=> mgmt_rvalid)
    else $error("no read answer in power down");
  a_reserved_zero: assert property (mgmt_rvalid |-> mgmt_rdata[6:0] == 7'h00)
    else $error("low bits not zero");
  a_pin_pdown: assert property (!basic_mode && !interrupt_powerdown_pin_n |=> phy_power_down)
    else $error("pin did not power down");
  a_isolate_quiet: assert property (!mii_rx_oe |-> mii_rx == '0 && !mii_col)
    else $error("isolated port still drives");
  // refclk enable moves with the isolate write, the mii enables one clock later
  a_refclk_gate: assert property (live_q |=> $past(refclk_out_en) ==
    !(!mii_rx_oe && $past(rmii_leader, 2)))
    else $error("reference clock enable wrong");
  a_col_oe_pair: assert property (mii_col_oe == mii_rx_oe)
    else $error("collision enable apart from receive enable");
  a_restart_gate: assert property (an_restart_req |-> an_enable)
    else $error("restart while negotiation off");
  a_restart_clear: assert property (s_an_started |=> !an_restart_req)
    else $error("restart not cleared");
  a_aneg_follow: assert property (live_q && an_enable |=> port_speed_100 == $past(an_speed_100)
    && port_full_duplex == $past(an_full_duplex))
    else $error("forced bits used while negotiating");
endmodule

// >>> sim/bmc_sme.sv
// management entity model: single reads and writes on the register port.
// assumes the bench calls its tasks only after reset is released.
`timescale 1ns/1ps
module bmc_sme (
  input wire logic clk,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid,
  output logic [4:0] mgmt_addr,
  output logic mgmt_wr,
  output logic mgmt_rd,
  output logic [15:0] mgmt_wdata
);
  localparam logic [4:0] SELF_TEST_OFFSET = 5'h16;

  initial
  begin
    mgmt_addr = 5'h1f;
    mgmt_wdata = 16'h0000;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
  end

  // released lines show the inverse so stale values never match
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr = 1'b1;
    @(negedge clk);
    mgmt_wr = 1'b0;
    mgmt_addr = ~a;
    mgmt_wdata = ~d;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    int n;
    @(negedge clk);
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    @(negedge clk);
    mgmt_rd = 1'b0;
    mgmt_addr = ~a;
    n = 0;
    while (mgmt_rvalid !== 1'b1 && n < 4)
    begin
      @(negedge clk);
      n++;
    end
    d = mgmt_rdata;
    if (n == 4)
    begin
      testbench.failures++;
      testbench.test_done();
    end
  endtask

  // loopback needs the self-test mode set too, 100 mbps pattern here
  task automatic loop_on(input logic [15:0] ctrl);
    wr(SELF_TEST_OFFSET, 16'h0004);
    wr(5'h00, ctrl);
  endtask
endmodule

// >>> sim/testbench.sv
// self-checking bench for the basic mode control register.
// assumes the management model drives the register port.
`timescale 1ns/1ps
module testbench;
  logic clk, reset, mgmt_wr, mgmt_rd, mgmt_rvalid, basic_mode, rmii_leader;
  logic strap_aneg_en, strap_speed_100, strap_full_duplex, strap_isolate;
  logic interrupt_powerdown_pin_n, an_initiated, an_speed_100, an_full_duplex;
  logic an_enable, an_restart_req, port_speed_100, port_full_duplex, phy_power_down;
  logic std_regs_reset, refclk_out_en, mii_tx_en, mii_tx_er, line_rx_dv, line_rx_er;
  logic line_crs, line_col, mii_rx_oe, mii_col, mii_col_oe;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata, rdw;
  logic [3:0] mii_txd, line_rxd;
  bmc_pkg::bmc_rx_t mii_rx;
  int failures, checked;

  bmc_basic_mode_control i_dut (.*);
  bmc_sme i_sme (.*);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input string what, input logic [15:0] exp);
    i_sme.rd(5'h00, rdw);
    chk(what, exp, rdw);
  endtask

  task automatic do_reset();
    reset = 1'b1;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // bounded wait on the collision output
  task automatic wait_col(input logic exp, input int lim);
    int n;
    n = 0;
    while (mii_col !== exp && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    chk("col", 16'(exp), 16'(mii_col));
  endtask

  task automatic test_done();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // basic pin mode first, straps give isolate and full duplex
  initial
  begin
    int n;
    failures = 0;
    checked = 0;
    reset = 1'b1;
    {basic_mode, rmii_leader, strap_aneg_en, strap_speed_100, strap_full_duplex, strap_isolate} = 6'h33;
    {interrupt_powerdown_pin_n, an_initiated, an_speed_100, an_full_duplex} = 4'hb;
    {mii_txd, mii_tx_en, mii_tx_er} = 6'h28;
    {line_rxd, line_rx_dv, line_rx_er, line_crs, line_col} = 8'h55;
    do_reset();
    rchk("strap word", 16'h0500);
    chk("strap speed", 16'h0000, 16'(port_speed_100));
    chk("iso oe refclk", 16'h0000, 16'({mii_rx_oe, refclk_out_en}));
    i_sme.wr(5'h00, 16'h207f);
    rchk("low bits", 16'h2000);
    chk("spd dpx", 16'h0002, 16'({port_speed_100, port_full_duplex}));
    chk("oe refclk", 16'h0003, 16'({mii_rx_oe, refclk_out_en}));
    chk("rx normal", 16'h0055, 16'({mii_rx, mii_col}));
    i_sme.wr(5'h00, 16'h2200);
    rchk("restart off", 16'h2000);
    // loopback: line side must vanish, col forced low
    i_sme.loop_on(16'h6000);
    mii_tx_en = 1'b1;
    repeat (2) @(negedge clk);
    chk("rx loop", 16'h00aa, 16'({mii_rx, mii_col}));
    mii_tx_en = 1'b0;
    i_sme.wr(5'h00, 16'h2080);
    mii_tx_en = 1'b1;
    wait_col(1'b1, bmc_pkg::COL_ASSERT_MAX_CYCLES);
    mii_tx_en = 1'b0;
    wait_col(1'b0, bmc_pkg::COL_DEASSERT_MAX_CYCLES);
    // aneg must already be on, else the restart bit of the same write is dropped
    i_sme.wr(5'h00, 16'h1000);
    i_sme.wr(5'h00, 16'h1200);
    rchk("restart set", 16'h1200);
    i_sme.wr(5'h00, 16'h1000);
    rchk("restart kept", 16'h1200);
    an_initiated = 1'b1;
    @(negedge clk);
    an_initiated = 1'b0;
    rchk("restart done", 16'h1000);
    chk("an spd dpx", 16'h0003, 16'({port_speed_100, port_full_duplex}));
    i_sme.wr(5'h00, 16'h0800);
    rchk("pdown word", 16'h0800);
    chk("pdown", 16'h0001, 16'(phy_power_down));
    // soft reset; the write inside it must be dropped
    i_sme.wr(5'h00, 16'h8000);
    i_sme.wr(5'h00, 16'h2000);
    i_sme.rd(5'h00, rdw);
    chk("busy", 16'h0001, 16'(rdw[15]));
    n = 0;
    while (rdw[15] !== 1'b0 && n < 40)
    begin
      i_sme.rd(5'h00, rdw);
      n++;
    end
    if (n == 40)
    begin
      failures++;
      test_done();
    end
    rchk("defaults", 16'h0500);
    // enhanced pin mode: no strap for speed, duplex or isolate
    {basic_mode, strap_aneg_en} = 2'h1;
    do_reset();
    rchk("enhanced", 16'h3100);
    interrupt_powerdown_pin_n = 1'b0;
    rchk("pin word", 16'h3900);
    chk("pin pdown", 16'h0001, 16'(phy_power_down));
    interrupt_powerdown_pin_n = 1'b1;
    // isolated without rmii leader: refclk keeps running, mii released
    rmii_leader = 1'b0;
    i_sme.wr(5'h00, 16'h0400);
    rchk("iso word", 16'h0400);
    chk("iso no leader", 16'h0001, 16'({mii_rx_oe, refclk_out_en}));
    chk("rx isolated", 16'h0000, 16'({mii_rx, mii_col, mii_col_oe}));
    i_sme.rd(5'h01, rdw);
    chk("unmapped", 16'h0000, rdw);
    test_done();
  end
endmodule

bind bmc_basic_mode_control bmc_chk i_chk (.*);
